//--- src/rsdb_converter.sv
// Registered converter between dual-basis and alpha-polynomial RS symbols.
//
// What this block does
// R1: Dual-basis symbol is vector z0..z7.
// R2: Conventional symbol is vector u7..u0.
// R3: Info converted in, check symbols converted out.
// R4: Paired core shares generator, length 255.
// R5: Forward: u times fixed matrix gives z.
// R6: Reverse: z times inverse matrix gives u.
// R7: All matrix sums are exclusive-OR.
// R8: Zero maps to zero, powers map uniquely.
// R9: One symbol per clock, registered, one-cycle latency.
`timescale 1ns/1ns
`include "rsdb_regs.svh"

module rsdb_converter
    import rsdb_pkg::*;
(
    // Clock, reset and freeze.
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic CE,
    // Information symbols from the source, dual basis.
    input wire logic DB_IN_VALID,
    input wire rsdb_sym_t DB_IN_SYM,
    // Information symbols to the encoder core, conventional form.
    output logic CV_OUT_VALID,
    output rsdb_sym_t CV_OUT_SYM,
    // Check symbols from the encoder core, conventional form.
    input wire logic CV_IN_VALID,
    input wire rsdb_sym_t CV_IN_SYM,
    // Check symbols back to the stream, dual basis.
    output logic DB_OUT_VALID,
    output rsdb_sym_t DB_OUT_SYM
);

    // The forward matrix, row r belonging to alpha^(7-r).
    localparam rsdb_mat_t T_FWD = {`RSDB_T_ROW7, `RSDB_T_ROW6, `RSDB_T_ROW5, `RSDB_T_ROW4,
                                   `RSDB_T_ROW3, `RSDB_T_ROW2, `RSDB_T_ROW1, `RSDB_T_ROW0};

    // Gauss-Jordan inversion over GF(2), evaluated once at elaboration.
    // Deriving the inverse from the forward matrix keeps the two tables from drifting apart.
    function automatic rsdb_mat_t mat_inv(input rsdb_mat_t m);
        rsdb_mat_t a;
        rsdb_mat_t b;
        logic [7:0] tmp;
        logic found;
        a = m;
        for (int r = 0; r < 8; r++) begin
            b[r] = 8'h80 >> r;
        end
        for (int c = 0; c < 8; c++) begin
            found = 1'b0;
            // Bring a row with a one in column c up to row c.
            for (int p = c; p < 8; p++) begin
                if (!found && a[p][7-c]) begin
                    found = 1'b1;
                    tmp = a[p];
                    a[p] = a[c];
                    a[c] = tmp;
                    tmp = b[p];
                    b[p] = b[c];
                    b[c] = tmp;
                end
            end
            // Clear column c from every other row; row addition is exclusive-OR.
            for (int r = 0; r < 8; r++) begin
                if (r != c && a[r][7-c]) begin
                    a[r] = a[r] ^ a[c]; // R7
                    b[r] = b[r] ^ b[c]; // R7
                end
            end
        end
        return b;
    endfunction

    // Row k of the inverse is the alpha-polynomial form of l(k), the element whose dual-basis form has only zk set.
    localparam rsdb_mat_t T_REV = mat_inv(T_FWD); // R6

    // Row vector times matrix. Input bit 7-r selects row r; the rows are summed modulo 2.
    // Both vectors are taken in printed order, so bit 7 holds z0 or u7.
    function automatic rsdb_sym_t vec_mul(input rsdb_sym_t v, input rsdb_mat_t m);
        rsdb_sym_t acc;
        acc = 8'h00;
        for (int r = 0; r < 8; r++) begin
            if (v[7-r]) begin
                acc = acc ^ m[r]; // R1 R2 R7
            end
        end
        return acc;
    endfunction

    // Reset synchroniser stages and the internal reset copy.
    logic rst_meta_r;
    logic rst_sync_r;

    // Release the asynchronous reset through two flops; assertion stays asynchronous.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // Pre-transform: dual-basis information symbols become conventional before the core.
    // The symbol register loads only with valid so an idle cycle keeps the last value.
    always_ff @(posedge CLK or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            CV_OUT_VALID <= `RSDB_VALID_RST; // R9
            CV_OUT_SYM <= 8'h00;
        end else if (CE) begin
            CV_OUT_VALID <= DB_IN_VALID; // R9
            if (DB_IN_VALID) begin
                CV_OUT_SYM <= vec_mul(DB_IN_SYM, T_REV); // R3 R6 R8
            end
        end
    end

    // Post-transform: check symbols from the core go back to dual basis.
    // The core itself must use the same generator over length 255; nothing here checks it.
    always_ff @(posedge CLK or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            DB_OUT_VALID <= `RSDB_VALID_RST; // R9
            DB_OUT_SYM <= 8'h00;
        end else if (CE) begin
            DB_OUT_VALID <= CV_IN_VALID; // R9
            if (CV_IN_VALID) begin
                DB_OUT_SYM <= vec_mul(CV_IN_SYM, T_FWD); // R3 R4 R5 R8
            end
        end
    end

    // Checks on the registered outputs.
    a_rev_latency: assert property (@(posedge CLK) disable iff (!rst_sync_r) // R9
        CE && DB_IN_VALID |=> CV_OUT_VALID && CV_OUT_SYM == vec_mul($past(DB_IN_SYM), T_REV))
        else $error("Reverse output not one cycle after input.");

    a_fwd_latency: assert property (@(posedge CLK) disable iff (!rst_sync_r) // R9
        CE && CV_IN_VALID |=> DB_OUT_VALID && DB_OUT_SYM == vec_mul($past(CV_IN_SYM), T_FWD))
        else $error("Forward output not one cycle after input.");

    a_idle_no_valid: assert property (@(posedge CLK) disable iff (!rst_sync_r) // R9
        CE && !DB_IN_VALID && !CV_IN_VALID |=> !CV_OUT_VALID && !DB_OUT_VALID)
        else $error("Valid raised without input.");

    a_freeze_holds: assert property (@(posedge CLK) disable iff (!rst_sync_r) // R9
        !CE |=> $stable(CV_OUT_SYM) && $stable(DB_OUT_SYM) && $stable(CV_OUT_VALID))
        else $error("State changed while clock enable low.");

    // The check path must freeze its valid flag too, or the stream would see a phantom symbol.
    a_freeze_fwd_valid: assert property (@(posedge CLK) disable iff (!rst_sync_r) // R9
        !CE |=> $stable(DB_OUT_VALID))
        else $error("Check valid changed while clock enable low.");

    // An idle cycle must not disturb the last converted information symbol.
    a_rev_idle_holds: assert property (@(posedge CLK) disable iff (!rst_sync_r) // R9
        CE && !DB_IN_VALID |=> $stable(CV_OUT_SYM))
        else $error("Information symbol changed without input.");

    // An idle cycle must not disturb the last converted check symbol.
    a_fwd_idle_holds: assert property (@(posedge CLK) disable iff (!rst_sync_r) // R9
        CE && !CV_IN_VALID |=> $stable(DB_OUT_SYM))
        else $error("Check symbol changed without input.");

    a_zero_maps_zero: assert property (@(posedge CLK) disable iff (!rst_sync_r) // R8
        CE && CV_IN_VALID && CV_IN_SYM == 8'h00 |=> DB_OUT_SYM == 8'h00)
        else $error("Zero symbol did not map to zero.");

    a_alpha0_fwd: assert property (@(posedge CLK) disable iff (!rst_sync_r) // R5
        CE && CV_IN_VALID && CV_IN_SYM == 8'h01 |=> DB_OUT_SYM == 8'h7b)
        else $error("Alpha to the zero converted wrongly.");

    a_example_rev: assert property (@(posedge CLK) disable iff (!rst_sync_r) // R6
        CE && DB_IN_VALID && DB_IN_SYM == 8'hb9 |=> CV_OUT_SYM == 8'h2a)
        else $error("Dual-basis 10111001 did not give 00101010.");

    a_round_trip: assert property (@(posedge CLK) disable iff (!rst_sync_r) // R3
        CE && DB_IN_VALID |=> vec_mul(CV_OUT_SYM, T_FWD) == $past(DB_IN_SYM))
        else $error("Reverse conversion is not undone by forward.");

    a_nonzero_stays: assert property (@(posedge CLK) disable iff (!rst_sync_r) // R8
        CE && CV_IN_VALID && CV_IN_SYM != 8'h00 |=> DB_OUT_SYM != 8'h00)
        else $error("Nonzero symbol mapped to zero.");

    // The zero element must also survive the reverse path unchanged.
    a_rev_zero: assert property (@(posedge CLK) disable iff (!rst_sync_r) // R8
        CE && DB_IN_VALID && DB_IN_SYM == 8'h00 |=> CV_OUT_SYM == 8'h00)
        else $error("Zero information symbol did not map to zero.");

    // The highest power in the polynomial form selects the first matrix row alone.
    a_alpha7_fwd: assert property (@(posedge CLK) disable iff (!rst_sync_r) // R5
        CE && CV_IN_VALID && CV_IN_SYM == 8'h80 |=> DB_OUT_SYM == 8'h8d)
        else $error("Alpha to the seventh converted wrongly.");

    // A check symbol with several bits set exercises the modulo-2 row sums.
    a_example_fwd: assert property (@(posedge CLK) disable iff (!rst_sync_r) // R7
        CE && CV_IN_VALID && CV_IN_SYM == 8'h59 |=> DB_OUT_SYM == 8'he8)
        else $error("Conventional 01011001 did not give 11101000.");

    // Main scenarios.
    c_both_paths: cover property (@(posedge CLK) disable iff (!rst_sync_r)
        CE && DB_IN_VALID && CV_IN_VALID);
    c_burst_rev: cover property (@(posedge CLK) disable iff (!rst_sync_r)
        (CE && DB_IN_VALID) [*4]);
    c_freeze_mid: cover property (@(posedge CLK) disable iff (!rst_sync_r)
        CE && CV_IN_VALID ##1 !CE ##1 CE && CV_IN_VALID);
    // Back-to-back check symbols from the core.
    c_burst_fwd: cover property (@(posedge CLK) disable iff (!rst_sync_r)
        (CE && CV_IN_VALID) [*4]);
    // A symbol that goes out to the core and comes back as a check symbol.
    c_round_trip: cover property (@(posedge CLK) disable iff (!rst_sync_r)
        CE && DB_IN_VALID ##2 CE && CV_IN_VALID ##1 DB_OUT_VALID);

endmodule

//--- src/rsdb_pkg.sv
// Types shared by the dual-basis symbol converter.
package rsdb_pkg;
    // One 8-bit symbol, either representation.
    typedef logic [7:0] rsdb_sym_t;
    // An 8x8 binary matrix, row index first, column 0 in bit 7 of each row.
    typedef logic [7:0][7:0] rsdb_mat_t;
endpackage

//--- src/rsdb_regs.svh
// Constants for the dual-basis symbol converter: the fixed basis-change matrix.
`ifndef RSDB_REGS_SVH
`define RSDB_REGS_SVH

// Rows of the forward matrix, one per power alpha^7 down to alpha^0.
// Each row is the dual-basis form z0..z7, with z0 in bit 7.
`define RSDB_T_ROW0 8'h8d
`define RSDB_T_ROW1 8'hef
`define RSDB_T_ROW2 8'hec
`define RSDB_T_ROW3 8'h86
`define RSDB_T_ROW4 8'hfa
`define RSDB_T_ROW5 8'h99
`define RSDB_T_ROW6 8'haf
`define RSDB_T_ROW7 8'h7b

// Symbol width and the code length that the paired encoder core must use.
`define RSDB_SYM_W 8
`define RSDB_CODE_LEN 255

// Reset value of every valid flag.
`define RSDB_VALID_RST 1'b0

`endif

//--- verif/rs_dual_basis_converter_tb_top.sv
// Self-checking bench for the converter: corner and random symbols on both paths.
`timescale 1ns/1ns
module rs_dual_basis_converter_tb_top
    import rsdb_pkg::*;
;
    logic CLK = 1'b0, RSTN = 1'b0, CE = 1'b1, DB_IN_VALID = 1'b0, stall = 1'b0;
    logic CV_OUT_VALID, CV_IN_VALID, DB_OUT_VALID;
    rsdb_sym_t DB_IN_SYM = 8'h00, CV_OUT_SYM, CV_IN_SYM, DB_OUT_SYM;
    // Expected outputs, worked out from what the design took at each edge.
    logic ev_cv = 1'b0, ev_db = 1'b0;
    rsdb_sym_t es_cv = 8'h00, es_db = 8'h00;
    int fail_count = 0, num_checks = 0, cyc = 0;
    // Dual-basis rows of alpha^7 down to alpha^0, z0 in bit 7.
    localparam rsdb_sym_t ROWS [8] = '{8'h8d, 8'hef, 8'hec, 8'h86, 8'hfa, 8'h99, 8'haf, 8'h7b};
    initial begin
        forever #2 CLK = ~CLK;
    end
    rsdb_converter rsdb_converter_inst (.CLK(CLK), .RSTN(RSTN), .CE(CE),
        .DB_IN_VALID(DB_IN_VALID), .DB_IN_SYM(DB_IN_SYM), .CV_OUT_VALID(CV_OUT_VALID),
        .CV_OUT_SYM(CV_OUT_SYM), .CV_IN_VALID(CV_IN_VALID), .CV_IN_SYM(CV_IN_SYM),
        .DB_OUT_VALID(DB_OUT_VALID), .DB_OUT_SYM(DB_OUT_SYM));
    rsdb_core_model rsdb_core_model_inst (.clk(CLK), .rstn(RSTN), .stall(stall),
        .in_valid(CV_OUT_VALID), .in_sym(CV_OUT_SYM), .chk_valid(CV_IN_VALID),
        .chk_sym(CV_IN_SYM));
    // Forward product: each set bit u(7-k) adds row k, sums taken modulo 2.
    function automatic rsdb_sym_t fwd(rsdb_sym_t u);
        rsdb_sym_t z;
        z = 8'h00;
        for (int k = 0; k < 8; k++) begin
            if (u[7-k]) z = z ^ ROWS[k];
        end
        return z;
    endfunction
    // Reverse found by search, so no inverse matrix has to be trusted.
    function automatic rsdb_sym_t rev(rsdb_sym_t z);
        rsdb_sym_t u;
        u = 8'h00;
        for (int i = 0; i < 256; i++) begin
            if (fwd(8'(i)) == z) u = 8'(i);
        end
        return u;
    endfunction
    task automatic check(string name, rsdb_sym_t seen, rsdb_sym_t exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic drive(logic ce, logic dv, rsdb_sym_t ds);
        @(negedge CLK);
        CE = ce;
        DB_IN_VALID = dv;
        DB_IN_SYM = ds;
    endtask
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Model of one accepted symbol per enabled edge; sampled before the design updates.
    // Reset is seen at once, as in the design, so a mid-run reset never races the checks.
    always @(posedge CLK or negedge RSTN) begin
        cyc <= cyc + 1;
        if (!RSTN) begin
            ev_cv <= 1'b0;
            ev_db <= 1'b0;
            es_cv <= 8'h00;
            es_db <= 8'h00;
        end else if (CE) begin
            ev_cv <= DB_IN_VALID;
            ev_db <= CV_IN_VALID;
            if (DB_IN_VALID) es_cv <= rev(DB_IN_SYM);
            if (CV_IN_VALID) es_db <= fwd(CV_IN_SYM);
        end
    end
    // Outputs are settled at the falling edge; a hang is cut short by the cycle ceiling.
    always @(negedge CLK) begin
        check("CV_OUT_VALID", {7'h00, CV_OUT_VALID}, {7'h00, ev_cv});
        check("CV_OUT_SYM", CV_OUT_SYM, es_cv);
        check("DB_OUT_VALID", {7'h00, DB_OUT_VALID}, {7'h00, ev_db});
        check("DB_OUT_SYM", DB_OUT_SYM, es_db);
        if (cyc == 3000) begin
            fail_count++;
            report_and_stop();
        end
    end
    initial begin
        void'($urandom(32'h5ca2));
        for (int r = 0; r < 2; r++) begin
            RSTN = 1'b0;
            repeat (2) drive(1'b1, 1'b0, 8'h00);
            RSTN = 1'b1;
            repeat (3) drive(1'b1, 1'b0, 8'h00);
            // Known pairs, then a round trip back to the dual-basis symbol.
            drive(1'b1, 1'b1, 8'hb9);
            drive(1'b1, 1'b1, 8'he8);
            check("b9 to conventional", CV_OUT_SYM, 8'h2a);
            drive(1'b1, 1'b1, 8'h00);
            check("e8 to conventional", CV_OUT_SYM, 8'h59);
            drive(1'b1, 1'b0, 8'h00);
            check("zero symbol", CV_OUT_SYM, 8'h00);
            check("b9 round trip", DB_OUT_SYM, 8'hb9);
            $display("Corner test %0d done", r);
            for (int i = 0; i < 400; i++) begin
                stall = ($urandom % 4) == 0;
                drive(($urandom % 4) != 0, $urandom % 2, 8'($urandom));
            end
            stall = 1'b0;
            $display("Random test %0d done", r);
        end
        report_and_stop();
    end
endmodule

//--- verif/rsdb_core_model.sv
// Behavioural model of the conventional encoder core that faces the converter.
`timescale 1ns/1ns
module rsdb_core_model
    import rsdb_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Stall request from the bench, to make the core drop the symbol of that cycle.
    input wire logic stall,
    // Conventional symbols arriving from the converter.
    input wire logic in_valid,
    input wire rsdb_sym_t in_sym,
    // Conventional check symbols sent back to the converter.
    output logic chk_valid,
    output rsdb_sym_t chk_sym
);
    // Each accepted symbol comes back as a check symbol, which makes the round trip visible.
    // An idle core keeps its bus toggling, so stale data never passes for a fresh symbol.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            chk_valid <= 1'b0;
            chk_sym <= 8'h00;
        end else begin
            chk_valid <= in_valid & ~stall;
            chk_sym <= (in_valid & ~stall) ? in_sym : ~chk_sym;
        end
    end
endmodule
